// ===== verilog/tam_pkg.sv
// Shared constants and carrier types for the two-input TDM audio mixer
package tam_pkg;

  // Frame geometry
  localparam int SMP_W      = 32;
  localparam int SLOTS      = 8;
  localparam int ATT_W      = 18;
  localparam int DIV_W      = 12;
  localparam int CNT_W      = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] LAST_BIT = 5'h1F;

  // Attenuator defaults
  localparam logic [17:0] ATT_INIT_RST = 18'h3FFFF;
  localparam logic [17:0] ATT_UP_RST   = 18'h2AAAA;
  localparam logic [17:0] ATT_DN_RST   = 18'h30000;
  localparam logic [17:0] ATT_TGT_RST  = 18'h00010;
  localparam logic [11:0] ATT_DIV_RST  = 12'h000;

  // Output source codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_IN1 = 2'h1;
  localparam logic [1:0] SRC_IN2 = 2'h2;
  localparam logic [1:0] SRC_MIX = 2'h3;

  // Output width codes and the low bits each one drops
  localparam logic [2:0] WID_16 = 3'h0;
  localparam logic [2:0] WID_18 = 3'h1;
  localparam logic [2:0] WID_20 = 3'h2;
  localparam logic [2:0] WID_24 = 3'h3;
  localparam logic [2:0] WID_32 = 3'h4;
  localparam logic [4:0] DROP_16 = 5'h10;
  localparam logic [4:0] DROP_18 = 5'h0E;
  localparam logic [4:0] DROP_20 = 5'h0C;
  localparam logic [4:0] DROP_24 = 5'h08;

  // Allowed period mismatch between inputs, in clk cycles
  localparam logic [15:0] ERR_TOL = 16'h0004;

  // Per-attenuator settings
  typedef struct packed {
    logic        en;
    logic        dir_up;
    logic [11:0] div;
    logic [17:0] init;
    logic [17:0] up;
    logic [17:0] dn;
    logic [17:0] tgt;
  } tam_atten_cfg_t;

  // Mixer-wide settings
  typedef struct packed {
    logic       clk_sel;
    logic [1:0] src;
    logic [2:0] width;
    logic       pol_neg;
    logic       frm_mask;
    logic       clk_mask;
    logic       sync_en;
    logic       sync_sel;
  } tam_cfg_t;

  // One serial output lane
  typedef struct packed {
    logic bclk;
    logic fs;
    logic data;
  } tam_lane_t;

  // Output sample tagged with its slot
  typedef struct packed {
    logic [2:0]  slot;
    logic [31:0] data;
  } tam_word_t;

  localparam tam_atten_cfg_t ATT_CFG_RST = '{1'b0, 1'b0, ATT_DIV_RST, ATT_INIT_RST,
                                              ATT_UP_RST, ATT_DN_RST, ATT_TGT_RST};
  localparam tam_cfg_t CFG_RST = '{1'b0, SRC_OFF, WID_32, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ===== verilog/tam_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and synchronous clear
module tam_fifo #(
  parameter int W     = 35,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clr,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW:0]             wp;
    logic [PW:0]             rp;
  } tam_fifo_st_t;

  tam_fifo_st_t q;
  tam_fifo_st_t d;

  // Full when pointers match except for the wrap bit
  assign in_ready  = !((q.wp[PW] != q.rp[PW]) && (q.wp[PW-1:0] == q.rp[PW-1:0]));
  assign out_valid = (q.wp != q.rp);
  assign out_data  = q.mem[q.rp[PW-1:0]];

  // Pointer and storage update
  always_comb begin
    d = q;
    if (clr) begin
      d.wp = '0;
      d.rp = '0;
    end else begin
      if (in_valid && in_ready) begin
        d.mem[q.wp[PW-1:0]] = in_data;
        d.wp = q.wp + {{PW{1'b0}}, 1'b1};
      end
      if (out_valid && out_ready) begin
        d.rp = q.rp + {{PW{1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ===== verilog/tam_mixer.sv
// Two-input TDM audio mixer: deserialize, attenuate, mix, quantize, reserialize
// Contract
// [R1] Two serial inputs: normal audio, safety tone
// [R2] Up to eight 32-bit slots per frame
// [R3] Slots 1-6 stereo pairs, last two spare
// [R4] Mixed inputs share channel count, frame rate
// [R5] Deserialize per own bit clock from sync
// [R6] Enabled attenuation multiplies by current value
// [R7] Disabled attenuation passes samples; reset disabled
// [R8] Two attenuators, each fully configured
// [R9] Mix sums same-slot attenuated samples
// [R10] Quantize to selected width, round LSB
// [R11] Serialize same layout on selected clock
// [R12] Mixing clock select, first input default
// [R13] Source: off, first, second, mixed
// [R14] Width codes 16/18/20/24/32, default 32
// [R15] Output edge select, negative default
// [R16] Frame and clock difference errors, maskable
// [R17] Sync mode enable and clock source
// [R18] Attenuator direction: down or up
// [R19] Step divider 0-4095 paces stepping
// [R20] Initial value, default full scale
// [R21] Step up and down factors
// [R22] Stepping stops at target value
// [R23] Attenuation is unsigned fraction of full
// [R24] Mixed output valid only with matched rates
// [R25] Output drives DAC and readback path
module tam_mixer (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // First serial input pins
  input  wire logic                          in1_bclk,
  input  wire logic                          in1_fs,
  input  wire logic                          in1_data,
  // Second serial input pins
  input  wire logic                          in2_bclk,
  input  wire logic                          in2_fs,
  input  wire logic                          in2_data,
  // Configuration
  input  wire tam_pkg::tam_cfg_t             cfg,
  input  wire tam_pkg::tam_atten_cfg_t [1:0] acfg,
  // Codec DAC lane
  output logic                               dac_bclk,
  output logic                               dac_fs,
  output logic                               dac_data,
  // Readback lane
  output logic                               rb_bclk,
  output logic                               rb_fs,
  output logic                               rb_data,
  // Errors
  output logic                               err_frm,
  output logic                               err_clk
);

  typedef struct packed {
    logic [5:0]                  sy1;
    logic [5:0]                  sy2;
    logic [5:0]                  prv;
    logic [1:0][31:0]            sh;
    logic [1:0][4:0]             bitn;
    logic [1:0][2:0]             slot;
    logic [1:0][7:0][31:0]       hold;
    logic [1:0][17:0]            att;
    logic [1:0][11:0]            divc;
    logic [1:0][15:0]            fcnt;
    logic [1:0][15:0]            fper;
    logic [1:0][15:0]            bcnt;
    logic [1:0][15:0]            bper;
    logic                        pend;
    logic [2:0]                  pslot;
    logic [31:0]                 osh;
    logic [4:0]                  ocnt;
    tam_pkg::tam_lane_t          dac;
    tam_pkg::tam_lane_t          rb;
    logic                        err_frm;
    logic                        err_clk;
  } tam_core_st_t;

  tam_core_st_t q;
  tam_core_st_t d;

  logic [1:0]          rise;
  logic [1:0]          fall;
  logic [1:0]          fstart;
  logic [1:0]          done;
  logic [1:0][31:0]    raw;
  logic [1:0][4:0]     bitc;
  logic [1:0][2:0]     slotc;
  logic                act;
  logic                fifo_clr;
  logic                push_v;
  logic                push_rdy;
  tam_pkg::tam_word_t  push_w;
  logic                pop_v;
  logic                pop_rdy;
  tam_pkg::tam_word_t  pop_w;
  logic [18:0]         up_v;

  // Sample times unsigned fraction value/2^18
  function automatic logic [31:0] tam_scale(input logic [31:0] x, input logic [17:0] a);
    logic signed [50:0] p;
    p = $signed(x) * $signed({1'b0, a});
    return p[49:18]; // [R23]
  endfunction

  // Attenuation value times a step factor
  function automatic logic [17:0] tam_frac(input logic [17:0] a, input logic [17:0] f);
    logic [35:0] p;
    p = a * f;
    return p[35:18];
  endfunction

  // Magnitude of a period mismatch
  function automatic logic [15:0] tam_diff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // Round half up at the kept LSB, saturate, clear dropped bits
  function automatic logic [31:0] tam_quant(input logic signed [32:0] s, input logic [2:0] w);
    logic signed [33:0] r;
    logic [4:0]         drop;
    logic [31:0]        m;
    case (w)
      tam_pkg::WID_16: drop = tam_pkg::DROP_16;
      tam_pkg::WID_18: drop = tam_pkg::DROP_18;
      tam_pkg::WID_20: drop = tam_pkg::DROP_20;
      tam_pkg::WID_24: drop = tam_pkg::DROP_24;
      default:         drop = 5'h00;
    endcase
    if (drop == 5'h00) begin
      r = {s[32], s};
    end else begin
      r = {s[32], s} + (34'sh1 <<< (drop - 5'h01)); // [R10]
    end
    m = 32'hFFFFFFFF << drop;
    if (r > 34'sh07FFFFFFF) begin
      return 32'h7FFFFFFF & m;
    end else if (r < -34'sh080000000) begin
      return 32'h80000000;
    end else begin
      return r[31:0] & m; // [R14]
    end
  endfunction

  // Output buffer; its fill-side ready holds the pending sample back
  tam_fifo #(
    .W     ($bits(tam_pkg::tam_word_t)),
    .DEPTH (tam_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .clr       (fifo_clr),
    .in_valid  (push_v),
    .in_data   (push_w),
    .in_ready  (push_rdy),
    .out_valid (pop_v),
    .out_data  (pop_w),
    .out_ready (pop_rdy)
  );

  // Whole datapath next state
  always_comb begin
    d        = q;
    d.sy1    = {in2_data, in2_fs, in2_bclk, in1_data, in1_fs, in1_bclk};
    d.sy2    = q.sy1;
    d.prv    = q.sy2;
    fifo_clr = 1'b0;
    push_v   = 1'b0;
    push_w   = '0;
    up_v     = '0;
    rise     = '0;
    fall     = '0;
    fstart   = '0;
    done     = '0;
    raw      = '0;
    bitc     = '0;
    slotc    = '0;
    // Each input runs on its own sampled bit clock
    for (int i = 0; i < 2; i++) begin // [R1] [R8]
      rise[i]   = q.sy2[3*i] & ~q.prv[3*i];
      fall[i]   = ~q.sy2[3*i] & q.prv[3*i];
      fstart[i] = rise[i] & q.sy2[3*i+1];
      raw[i]    = {q.sh[i][30:0], q.sy2[3*i+2]};
      if (fstart[i]) begin
        bitc[i]  = 5'h00; // [R5]
        slotc[i] = 3'h0;
      end else if (q.bitn[i] == tam_pkg::LAST_BIT) begin
        bitc[i]  = 5'h00;
        slotc[i] = q.slot[i] + 3'h1; // [R2]
      end else begin
        bitc[i]  = q.bitn[i] + 5'h01;
        slotc[i] = q.slot[i];
      end
      // Slot wraps after eight; spare slots travel like the rest
      done[i] = rise[i] & (bitc[i] == tam_pkg::LAST_BIT); // [R3]
      // Period counters saturate so a stopped clock reads as slow
      if (q.fcnt[i] != 16'hFFFF) begin
        d.fcnt[i] = q.fcnt[i] + 16'h0001;
      end
      if (q.bcnt[i] != 16'hFFFF) begin
        d.bcnt[i] = q.bcnt[i] + 16'h0001;
      end
      if (rise[i]) begin
        d.sh[i]   = raw[i];
        d.bitn[i] = bitc[i];
        d.slot[i] = slotc[i];
        d.bper[i] = q.bcnt[i];
        d.bcnt[i] = 16'h0000;
      end
      if (fstart[i]) begin
        d.fper[i] = q.fcnt[i];
        d.fcnt[i] = 16'h0000;
      end
      if (done[i]) begin
        d.hold[i][slotc[i]] = acfg[i].en ? tam_scale(raw[i], q.att[i]) : raw[i]; // [R6] [R7]
      end
      // Profile: reload while disabled, step once per divided frame
      if (!acfg[i].en) begin
        d.att[i]  = acfg[i].init; // [R20]
        d.divc[i] = 12'h000;
      end else if (fstart[i]) begin
        if (q.divc[i] >= acfg[i].div) begin // [R19]
          d.divc[i] = 12'h000;
          if (!acfg[i].dir_up && (q.att[i] > acfg[i].tgt)) begin // [R18]
            d.att[i] = (tam_frac(q.att[i], acfg[i].dn) > acfg[i].tgt) ?
                       tam_frac(q.att[i], acfg[i].dn) : acfg[i].tgt; // [R21] [R22]
          end else if (acfg[i].dir_up && (q.att[i] < acfg[i].tgt)) begin
            // Plus one so a zero value can still climb
            up_v = {1'b0, q.att[i]} + {1'b0, tam_frac(q.att[i], acfg[i].up)} + 19'h00001; // [R21]
            d.att[i] = (up_v > {1'b0, acfg[i].tgt}) ? acfg[i].tgt : up_v[17:0]; // [R22]
          end
        end else begin
          d.divc[i] = q.divc[i] + 12'h001;
        end
      end
    end

    // Input mismatch detection, mask forces the flag low
    d.err_frm = (tam_diff(q.fper[0], q.fper[1]) > tam_pkg::ERR_TOL) & ~cfg.frm_mask; // [R16]
    d.err_clk = (tam_diff(q.bper[0], q.bper[1]) > tam_pkg::ERR_TOL) & ~cfg.clk_mask; // [R16]

    // Mix one slot after the selected input finishes it
    if (q.pend) begin
      push_v      = 1'b1;
      push_w.slot = q.pslot;
      case (cfg.src) // [R13]
        tam_pkg::SRC_IN1: push_w.data = tam_quant({q.hold[0][q.pslot][31], q.hold[0][q.pslot]}, cfg.width);
        tam_pkg::SRC_IN2: push_w.data = tam_quant({q.hold[1][q.pslot][31], q.hold[1][q.pslot]}, cfg.width);
        tam_pkg::SRC_MIX: push_w.data = tam_quant($signed({q.hold[0][q.pslot][31], q.hold[0][q.pslot]}) +
                                                  $signed({q.hold[1][q.pslot][31], q.hold[1][q.pslot]}),
                                                  cfg.width); // [R9] [R24]
        default:          push_w.data = 32'h00000000;
      endcase
      if (push_rdy) begin
        d.pend = 1'b0;
      end
    end
    // New slot wins over the clear of the old one
    if (done[cfg.clk_sel]) begin // [R12]
      d.pend  = 1'b1;
      d.pslot = slotc[cfg.clk_sel];
    end

    // Serializer on the chosen edge of the mixing clock
    act     = cfg.pol_neg ? fall[cfg.clk_sel] : rise[cfg.clk_sel]; // [R15]
    pop_rdy = act && (q.ocnt == 5'h00);
    d.dac.bclk = q.sy2[3*cfg.clk_sel];
    if (act) begin // [R11]
      d.ocnt = q.ocnt + 5'h01;
      if (q.ocnt == 5'h00) begin
        d.osh      = pop_v ? {pop_w.data[30:0], 1'b0} : 32'h00000000;
        d.dac.data = pop_v & pop_w.data[31];
        d.dac.fs   = pop_v & (pop_w.slot == 3'h0);
      end else begin
        d.osh      = {q.osh[30:0], 1'b0};
        d.dac.data = q.osh[31];
        d.dac.fs   = 1'b0;
      end
    end
    // Sync mode realigns output to the chosen input's frame; an aligned stream is left alone
    // so a steady frame loses no buffered word, and a same-edge act counts as the first bit
    if (cfg.sync_en && fstart[cfg.sync_sel] && (q.ocnt != 5'h00)) begin // [R17]
      fifo_clr = 1'b1;
      d.ocnt   = act ? 5'h01 : 5'h00;
    end
    d.rb = d.dac; // [R25]
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Pin outputs straight from flops
  assign dac_bclk = q.dac.bclk;
  assign dac_fs   = q.dac.fs;
  assign dac_data = q.dac.data;
  assign rb_bclk  = q.rb.bclk;
  assign rb_fs    = q.rb.fs;
  assign rb_data  = q.rb.data;
  assign err_frm  = q.err_frm;
  assign err_clk  = q.err_clk;

  // Checks on the datapath
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_frame_start;
    rise[0] && q.sy2[1];
  endsequence

  sequence s_sel_slot_done;
    done[1] && cfg.clk_sel;
  endsequence

  a_slot_from_sync: assert property (s_frame_start |=> (q.bitn[0] == 5'h00) && (q.slot[0] == 3'h0)) // [R5]
    else $error("slot count not restarted by frame sync");
  a_bypass_raw: assert property (done[0] && !acfg[0].en |=> q.hold[0][$past(slotc[0])] == $past(raw[0])) // [R7]
    else $error("disabled attenuator altered sample");
  a_scale_mult: assert property (done[1] && acfg[1].en |=>
                                 q.hold[1][$past(slotc[1])] == tam_scale($past(raw[1]), $past(q.att[1]))) // [R6]
    else $error("attenuated sample wrong");
  a_init_reload: assert property (!acfg[0].en |=> q.att[0] == $past(acfg[0].init)) // [R20]
    else $error("attenuation not reloaded while disabled");
  a_down_target: assert property (acfg[0].en && !acfg[0].dir_up && q.att[0] >= acfg[0].tgt && $stable(acfg[0])
                                  |=> q.att[0] >= $past(acfg[0].tgt)) // [R22]
    else $error("downward step passed target");
  a_mix_pending: assert property (s_sel_slot_done |=> q.pend && (q.pslot == $past(slotc[1]))) // [R12]
    else $error("selected clock slot not queued for mixing");
  a_off_zero: assert property (push_v && cfg.src == tam_pkg::SRC_OFF |-> push_w.data == 32'h00000000) // [R13]
    else $error("disabled output carries data");
  a_width_16: assert property (push_v && cfg.width == tam_pkg::WID_16 |-> push_w.data[15:0] == 16'h0000) // [R10]
    else $error("16-bit output has low bits set");
  a_first_bit: assert property (pop_rdy && pop_v |=>
                                dac_data == $past(pop_w.data[31]) && dac_fs == ($past(pop_w.slot) == 3'h0)) // [R11]
    else $error("serializer first bit wrong");
  a_sync_align: assert property (cfg.sync_en && fstart[cfg.sync_sel] && !act |=> q.ocnt == 5'h00) // [R17]
    else $error("sync mode left output bit count off frame");
  a_pol_edge: assert property ($changed(dac_data) |-> $past(act)) // [R15]
    else $error("output data moved off the selected edge");
  a_err_mask: assert property (cfg.frm_mask |=> !err_frm) // [R16]
    else $error("masked frame error still raised");

endmodule

// ===== sim/tam_partner.sv
// Far-side models: one TDM audio source and the codec DAC receiver
module tam_tdm_src (
  // Serial lane into the mixer
  output logic bclk,
  output logic fs,
  output logic data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] smp [8];
  real         half_ns = 62.5;
  bit          run     = 1'h0;

  // Frames back to back while run is set; the clock stands still otherwise
  initial begin
    bclk = 1'h0;
    fs   = 1'h0;
    data = 1'h0;
    forever begin
      wait (run);
      for (int s = 0; s < 8; s++) begin
        for (int b = 31; b >= 0; b--) begin
          fs   = (s == 0 && b == 31); // Sync on the first bit of slot 0
          data = smp[s][b]; // MSB first, launched on the falling edge
          #(half_ns) bclk = 1'h1;
          #(half_ns) bclk = 1'h0;
        end
      end
      fs   = 1'h0;
      data = ~data; // Idle line never shows a stale bit
    end
  end
endmodule

module tam_dac_rx (
  // Lane from the mixer
  input  wire logic bclk,
  input  wire logic fs,
  input  wire logic data,
  // Launch edge in use, 1 means falling
  input  wire logic pol_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rx [8];
  logic [31:0] sh     = 32'h0;
  int          nbit   = 0;
  int          slot   = 8;
  int          frames = 0;

  // Sample on the edge opposite to launch, where the bit has settled
  always @(bclk) begin
    if (bclk === pol_neg) begin
      if (fs === 1'h1) begin
        slot = 0;
        nbit = 0;
      end
      if (slot < 8) begin
        sh = {sh[30:0], data};
        nbit++;
        if (nbit == 32) begin
          rx[slot] = sh;
          nbit     = 0;
          slot++;
          frames += (slot == 8);
        end
      end
    end
  end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the two-input TDM audio mixer
`define check_eq(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Clock, reset and settings
  logic                          clk  = 1'h0;
  logic                          nrst = 1'h0;
  tam_pkg::tam_cfg_t             cfg;
  tam_pkg::tam_atten_cfg_t [1:0] acfg;
  // Serial lanes and flags
  logic                          in1_bclk, in1_fs, in1_data, in2_bclk, in2_fs, in2_data;
  logic                          dac_bclk, dac_fs, dac_data, rb_bclk, rb_fs, rb_data, err_frm, err_clk;
  // Bookkeeping
  int                            errors       = 0;
  int                            total_checks = 0;
  logic                          rb_diff      = 1'h0;
  logic [2:0]                    wid_tab [7]  = '{3'h4, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
  int                            wd [5]       = '{16, 18, 20, 24, 32};

  always #5 clk = ~clk;

  // Far side and design
  tam_tdm_src i_src1 (.bclk(in1_bclk), .fs(in1_fs), .data(in1_data));
  tam_tdm_src i_src2 (.bclk(in2_bclk), .fs(in2_fs), .data(in2_data));
  tam_dac_rx  i_rx   (.bclk(dac_bclk), .fs(dac_fs), .data(dac_data), .pol_neg(cfg.pol_neg));
  tam_mixer   i_dut  (.clk(clk), .nrst(nrst), .in1_bclk(in1_bclk), .in1_fs(in1_fs), .in1_data(in1_data),
                      .in2_bclk(in2_bclk), .in2_fs(in2_fs), .in2_data(in2_data), .cfg(cfg), .acfg(acfg),
                      .dac_bclk(dac_bclk), .dac_fs(dac_fs), .dac_data(dac_data), .rb_bclk(rb_bclk),
                      .rb_fs(rb_fs), .rb_data(rb_data), .err_frm(err_frm), .err_clk(err_clk));

  // Readback lane must mirror the DAC lane at every cycle
  always @(negedge clk) begin
    if ({rb_bclk, rb_fs, rb_data} !== {dac_bclk, dac_fs, dac_data}) rb_diff <= 1'h1;
  end

  // Attenuator reference with a static level (target equals initial value)
  function automatic logic [31:0] att(logic [31:0] s, tam_pkg::tam_atten_cfg_t c);
    longint p;
    p = longint'($signed(s)) * longint'(c.init);
    return c.en ? 32'(p >>> 18) : s;
  endfunction

  // Round at the kept LSB, saturate, then clear the dropped bits
  function automatic logic [31:0] quant(logic signed [32:0] sum, logic [2:0] w);
    logic signed [33:0] r;
    int                 drop;
    drop = 32 - wd[w];
    r    = sum;
    if (drop > 0) r += 34'sh1 <<< (drop - 1);
    if (r > 34'sh07FFFFFFF) r = 34'sh07FFFFFFF;
    if (r < -34'sh080000000) r = -34'sh080000000;
    return r[31:0] & ~((32'h1 << drop) - 32'h1);
  endfunction

  // Bounded wait for received output frames
  task automatic wait_frames(int n);
    int f;
    f = i_rx.frames;
    for (int i = 0; i < 8000 * n && i_rx.frames < f + n; i++) @(negedge clk);
    `check_eq(i_rx.frames, f + n)
  endtask

  // Second frame after a change is the first one fully built with it
  task automatic check_out();
    logic signed [32:0] a;
    logic signed [32:0] b;
    logic [31:0]        e;
    wait_frames(2);
    for (int k = 0; k < 8; k++) begin
      a = $signed(att(i_src1.smp[k], acfg[0]));
      b = $signed(att(i_src2.smp[k], acfg[1]));
      case (cfg.src)
        tam_pkg::SRC_IN1: e = quant(a, cfg.width);
        tam_pkg::SRC_IN2: e = quant(b, cfg.width);
        default:          e = quant(a + b, cfg.width);
      endcase
      `check_eq(i_rx.rx[k], e)
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cfg  = tam_pkg::CFG_RST;
    acfg = {2{tam_pkg::ATT_CFG_RST}};
    i_src1.smp = '{32'h7FFFFFF0, 32'h80000010, 32'h12345678, 32'hFEDCBA98,
                   32'h00008000, 32'hFFFF7FFF, 32'h40000000, 32'h00000001};
    i_src2.smp = '{32'h00000100, 32'hFFFFFF00, 32'h11111111, 32'h00000003,
                   32'h00007FFF, 32'h00000001, 32'h40000000, 32'hFFFFFFFF};
    repeat (6) @(negedge clk);
    `check_eq({dac_bclk, dac_fs, dac_data, rb_bclk, rb_fs, rb_data, err_frm, err_clk}, 8'h00)
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    i_src1.run = 1'h1;
    #40;
    i_src2.run = 1'h1;
    // Output disabled by default: frames carry only silence, rates match
    repeat (3300) @(negedge clk);
    `check_eq({err_frm, err_clk}, 2'h0)
    wait_frames(1);
    for (int k = 0; k < 8; k++) `check_eq(i_rx.rx[k], 32'h00000000)
    // Every non-off source code and every width code
    for (int t = 0; t < 7; t++) begin
      cfg.src   = (t == 0) ? tam_pkg::SRC_IN1 : (t == 1) ? tam_pkg::SRC_IN2 : tam_pkg::SRC_MIX;
      cfg.width = wid_tab[t];
      check_out();
    end
    cfg.clk_sel = 1'h1;
    check_out();
    // Half level on the first stream; second stays disabled despite its level
    acfg[0].init = 18'h20000;
    acfg[0].tgt  = 18'h20000;
    acfg[1].init = 18'h10000;
    @(negedge clk);
    acfg[0].en = 1'h1;
    check_out();
    cfg.pol_neg = 1'h0;
    check_out();
    // Sync to the first input; the realigned stream must still carry every slot
    cfg.sync_en = 1'h1;
    check_out();
    // Second input slowed well past the tolerance
    i_src2.half_ns = 100.0;
    repeat (14000) @(negedge clk);
    `check_eq({err_frm, err_clk}, 2'h3)
    cfg.frm_mask = 1'h1;
    repeat (4) @(negedge clk);
    `check_eq({err_frm, err_clk}, 2'h1)
    cfg.clk_mask = 1'h1;
    repeat (4) @(negedge clk);
    `check_eq({err_frm, err_clk}, 2'h0)
    `check_eq(rb_diff, 1'h0)
    stop_test();
  end

  // Watchdog a margin past the planned run of roughly 880 us, under the cycle budget
  initial begin
    #950us;
    errors++;
    stop_test();
  end
endmodule
